// >>> hw/cfg_port_pkg.sv
// constants and carrier types for the two-wire configuration port
// assumes a 20 MHz core clock and a separate crystal-rate link clock
package cfg_port_pkg;
    localparam int ADDR_W = 7;
    localparam int REG_AW = 5;
    localparam int NUM_REGS = 28;
    localparam logic [REG_AW-1:0] LAST_REG = 5'h1B;
    localparam int DEGLITCH = 3;
    localparam int PD_REG = 2;
    localparam int PD_BIT = 5;
    localparam int TRI_REG = 5;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [1:0] TRI_NONE = 2'h0;

    typedef struct packed {
        logic wr;
        logic [REG_AW-1:0] idx;
        logic [7:0] data;
    } reg_wr_t;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_ADDR = 5'b00010,
        ST_INDEX = 5'b00100,
        ST_WRITE = 5'b01000,
        ST_READ = 5'b10000
    } bus_state_t;
endpackage

// >>> hw/serial_config_port.sv
// two-wire serial configuration port with register file and output gating
// assumes: LINK_CLK is the crystal clock, SCL/SDA external open-drain wires
`timescale 1ns/1ns
module serial_config_port
    import cfg_port_pkg::*;
(
    // core clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // crystal clock of the serial link logic
    input wire logic LINK_CLK,
    // two-wire bus
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE_N,
    // address straps and sleep
    input wire logic [ADDR_W-1:0] BUS_ID_STRAPS,
    input wire logic SLEEP_INPUT,
    // link output enable
    output logic LINK_OUT_EN
);
    // link-domain reset synchroniser
    logic [1:0] lrst_reg;
    always_ff @(posedge LINK_CLK)
    begin
        lrst_reg <= {lrst_reg[0], RST_N};
    end
    wire logic lrst_n = lrst_reg[1];

    // three-stage pin sampling; deglitch filter on scl
    logic [2:0] scl_sync_reg, sda_sync_reg;
    logic [DEGLITCH-1:0] scl_hist_reg, sda_hist_reg;
    logic scl_reg, sda_reg, scl_prev_reg, sda_prev_reg;
    always_ff @(posedge LINK_CLK)
    begin
        scl_sync_reg <= {scl_sync_reg[1:0], SCL_IN};
        sda_sync_reg <= {sda_sync_reg[1:0], SDA_IN};
        if (!lrst_n)
        begin
            scl_hist_reg <= '1;
            sda_hist_reg <= '1;
            scl_reg <= 1'b1;
            sda_reg <= 1'b1;
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
        end
        else
        begin
            // sda delayed as far as the scl filter, so a data change
            // right at the clock fall is never taken for start or stop
            if (sda_sync_reg[2] == sda_sync_reg[1])
                sda_hist_reg <= {sda_hist_reg[DEGLITCH-2:0], sda_sync_reg[2]};
            sda_reg <= sda_hist_reg[DEGLITCH-1];
            if (scl_sync_reg[2] == scl_sync_reg[1])
                scl_hist_reg <= {scl_hist_reg[DEGLITCH-2:0], scl_sync_reg[2]};
            if (&scl_hist_reg)
                scl_reg <= 1'b1;
            else if (~|scl_hist_reg)
                scl_reg <= 1'b0;
            scl_prev_reg <= scl_reg;
            sda_prev_reg <= sda_reg;
        end
    end
    wire logic scl_rise = scl_reg && !scl_prev_reg;
    wire logic scl_fall = !scl_reg && scl_prev_reg;
    wire logic start_det = scl_reg && scl_prev_reg && sda_prev_reg && !sda_reg;
    wire logic stop_det = scl_reg && scl_prev_reg && !sda_prev_reg && sda_reg;

    // straps loaded while link reset is held, kept from its release on
    logic [ADDR_W-1:0] id_reg;
    always_ff @(posedge LINK_CLK)
    begin
        if (!lrst_n)
            id_reg <= BUS_ID_STRAPS;
    end

    // register file lives in link domain
    logic [7:0] regs_reg [NUM_REGS];
    bus_state_t state_reg;
    logic [3:0] bit_reg;
    logic [7:0] shift_reg;
    logic [REG_AW-1:0] ptr_reg;
    logic ack_reg, drive_low_reg, rd_nack_reg;
    reg_wr_t wr_next;

    always_comb
    begin
        wr_next.wr = (state_reg == ST_WRITE) && scl_rise && bit_reg == 4'h7
            && ptr_reg <= LAST_REG;
        wr_next.idx = ptr_reg;
        wr_next.data = {shift_reg[6:0], sda_reg};
    end

    always_ff @(posedge LINK_CLK)
    begin
        if (!lrst_n)
        begin
            for (int i = 0; i < NUM_REGS; i++)
                regs_reg[i] <= REG_RESET;
        end
        else if (wr_next.wr)
            regs_reg[wr_next.idx] <= wr_next.data;
    end

    // bit counter: 0..7 data, 8 ack clock
    always_ff @(posedge LINK_CLK)
    begin
        if (!lrst_n || start_det || stop_det)
        begin
            state_reg <= start_det ? ST_ADDR : ST_IDLE;
            bit_reg <= 4'h0;
            ack_reg <= 1'b0;
            rd_nack_reg <= 1'b0;
        end
        else if (state_reg != ST_IDLE)
        begin
            if (scl_rise)
            begin
                if (bit_reg == 4'h8)
                begin
                    rd_nack_reg <= (state_reg == ST_READ) && sda_reg;
                    ack_reg <= 1'b0;
                    bit_reg <= 4'h0;
                end
                else
                begin
                    shift_reg <= {shift_reg[6:0], sda_reg};
                    bit_reg <= bit_reg + 4'h1;
                end
                if (bit_reg == 4'h7)
                begin
                    unique case (state_reg)
                        ST_ADDR:
                        begin
                            if (shift_reg[6:0] == id_reg)
                            begin
                                ack_reg <= 1'b1;
                                state_reg <= sda_reg ? ST_READ : ST_INDEX;
                            end
                            else
                                state_reg <= ST_IDLE;
                        end
                        ST_INDEX, ST_WRITE:
                        begin
                            ack_reg <= 1'b1;
                            state_reg <= ST_WRITE;
                        end
                        ST_READ:
                            ack_reg <= 1'b0;
                        default:
                            state_reg <= ST_IDLE;
                    endcase
                end
            end
        end
    end

    // pointer: set by index byte, bumped after every data byte
    always_ff @(posedge LINK_CLK)
    begin
        if (!lrst_n)
            ptr_reg <= '0;
        else if (scl_rise && bit_reg == 4'h7)
        begin
            // index past the last register sets the pointer out of range; the next data byte wraps it to 0
            if (state_reg == ST_INDEX)
                ptr_reg <= ({shift_reg[6:0], sda_reg} > 8'(LAST_REG)) ? '1
                    : REG_AW'({shift_reg[6:0], sda_reg});
            else if (state_reg == ST_WRITE || state_reg == ST_READ)
                ptr_reg <= (ptr_reg == LAST_REG) ? '0 : ptr_reg + 1'b1;
        end
    end

    // sda drive updated only on delayed falling clock, and released on start or stop
    logic [7:0] rd_byte;
    assign rd_byte = (ptr_reg <= LAST_REG) ? regs_reg[ptr_reg] : REG_RESET;
    always_ff @(posedge LINK_CLK)
    begin
        if (!lrst_n || start_det || stop_det)
            drive_low_reg <= 1'b0;
        else if (scl_fall)
        begin
            if (ack_reg && bit_reg == 4'h8)
                drive_low_reg <= 1'b1;
            else if (state_reg == ST_READ && bit_reg < 4'h8 && !rd_nack_reg)
                drive_low_reg <= !rd_byte[3'(4'h7 - bit_reg)];
            else
                drive_low_reg <= 1'b0;
        end
    end
    assign SDA_OUT = 1'b0;
    assign SDA_OE_N = !drive_low_reg;

    // control bits cross to core domain, three flops, two agree
    logic pd_l;
    logic [1:0] tri_l;
    assign pd_l = regs_reg[PD_REG][PD_BIT];
    assign tri_l = regs_reg[TRI_REG][1:0];
    logic [2:0] pd_sync_reg, slp_sync_reg;
    logic [2:0] tri_sync_reg [2];
    logic pd_c_reg, slp_c_reg, en_reg;
    logic [1:0] tri_c_reg;
    always_ff @(posedge CLK)
    begin
        pd_sync_reg <= {pd_sync_reg[1:0], pd_l};
        slp_sync_reg <= {slp_sync_reg[1:0], SLEEP_INPUT};
        for (int i = 0; i < 2; i++)
            tri_sync_reg[i] <= {tri_sync_reg[i][1:0], tri_l[i]};
    end
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            pd_c_reg <= 1'b0;
            slp_c_reg <= 1'b0;
            tri_c_reg <= TRI_NONE;
            en_reg <= 1'b0;
        end
        else
        begin
            if (pd_sync_reg[2] == pd_sync_reg[1])
                pd_c_reg <= pd_sync_reg[2];
            if (slp_sync_reg[2] == slp_sync_reg[1])
                slp_c_reg <= slp_sync_reg[2];
            for (int i = 0; i < 2; i++)
                if (tri_sync_reg[i][2] == tri_sync_reg[i][1])
                    tri_c_reg[i] <= tri_sync_reg[i][2];
            en_reg <= !(pd_c_reg || slp_c_reg || tri_c_reg != TRI_NONE);
        end
    end
    assign LINK_OUT_EN = en_reg;

    // checks
    sequence s_sleep_seen;
        slp_c_reg;
    endsequence
    a_sleep_disables: assert property (@(posedge CLK)
        disable iff (!RST_N) s_sleep_seen |=> !LINK_OUT_EN)
        else $error("link outputs not disabled in sleep");
    a_tri_disables: assert property (@(posedge CLK)
        disable iff (!RST_N) (tri_c_reg != TRI_NONE || pd_c_reg)
        |=> !LINK_OUT_EN)
        else $error("link outputs not disabled by register");
    a_all_enable: assert property (@(posedge CLK)
        disable iff (!RST_N)
        (!slp_c_reg && !pd_c_reg && tri_c_reg == TRI_NONE) |=> LINK_OUT_EN)
        else $error("link outputs not enabled");
    a_sda_on_fall: assert property (@(posedge LINK_CLK)
        disable iff (!lrst_n)
        (!start_det && !stop_det && !scl_fall) |=> $stable(SDA_OE_N))
        else $error("sda changed outside falling clock");
    a_ptr_advance: assert property (@(posedge LINK_CLK)
        disable iff (!lrst_n) (scl_rise && bit_reg == 4'h7
        && state_reg == ST_WRITE && ptr_reg != LAST_REG)
        |=> ptr_reg == $past(ptr_reg) + 1'b1)
        else $error("pointer did not advance");
    a_ptr_wrap: assert property (@(posedge LINK_CLK)
        disable iff (!lrst_n) (scl_rise && bit_reg == 4'h7
        && state_reg == ST_READ && ptr_reg == LAST_REG) |=> ptr_reg == '0)
        else $error("pointer did not wrap");
    a_start_addr: assert property (@(posedge LINK_CLK)
        disable iff (!lrst_n)
        start_det |=> state_reg == ST_ADDR && bit_reg == 4'h0)
        else $error("start not taken");
    a_stop_idle: assert property (@(posedge LINK_CLK)
        disable iff (!lrst_n)
        stop_det |=> state_reg == ST_IDLE ##1 !drive_low_reg)
        else $error("stop not taken");
    a_ack_match: assert property (@(posedge LINK_CLK)
        disable iff (!lrst_n) (state_reg == ST_ADDR && scl_rise
        && bit_reg == 4'h7 && shift_reg[6:0] != id_reg)
        |=> !ack_reg ##1 !drive_low_reg)
        else $error("acked foreign address");
    a_open_drain: assert property (@(posedge LINK_CLK)
        disable iff (!lrst_n) !SDA_OE_N |-> SDA_OUT == 1'b0)
        else $error("sda driven high");
endmodule

// >>> test/bus_host.sv
// two-wire bus host model: drives the clock, pulls data low or lets go
// assumes: sda_in is the resolved wire with a pull-up, clk is 50 ns
`timescale 1ns/1ns
module bus_host
(
    // pacing clock
    input wire logic clk,
    // two-wire bus
    output logic scl,
    output logic sda_low,
    input wire logic sda_in
);
    logic glitch = 1'b0;
    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // each phase is well over eight link clocks
    task automatic half();
        repeat (20) @(posedge clk);
        #2;
    endtask
    // also serves as a repeated start
    task automatic start();
        sda_low = 1'b0;
        half();
        scl = 1'b1;
        half();
        sda_low = 1'b1;
        half();
        scl = 1'b0;
    endtask
    task automatic stop();
        sda_low = 1'b1;
        half();
        scl = 1'b1;
        half();
        sda_low = 1'b0;
        half();
    endtask
    // nine clocks, msb first; tx[0] is our ack, rx[0] the device's
    task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
        for (int i = 8; i >= 0; i--)
        begin
            sda_low = ~tx[i];
            if (glitch)
            begin
                #300 scl = 1'b1;
                #30 scl = 1'b0;
            end
            half();
            scl = 1'b1;
            half();
            rx[i] = sda_in;
            scl = 1'b0;
        end
    endtask
endmodule

// >>> test/tb.sv
// self-checking bench for the two-wire configuration port
// assumes: host model in bus_host, design in hw/serial_config_port.sv
`timescale 1ns/1ns
module tb;
    import cfg_port_pkg::*;
    localparam logic [ADDR_W-1:0] MY_ID = 7'h2D;
    logic clk = 1'b0;
    logic link_clk = 1'b0;
    logic rst_n = 1'b0;
    logic sleep = 1'b0;
    logic scl;
    logic sda_low;
    logic sda_oe_n;
    logic sda_out;
    logic link_en;
    logic sda_wire;
    logic oe_prev = 1'b1;
    logic [8:0] rx;
    int fail_count = 0;
    int num_checks = 0;
    int cycles = 0;
    always #25 clk = ~clk;
    always #32 link_clk = ~link_clk;
    assign sda_wire = ~sda_low & (sda_oe_n | sda_out);
    serial_config_port u_dut (.CLK(clk), .RST_N(rst_n), .LINK_CLK(link_clk),
        .SCL_IN(scl), .SDA_IN(sda_wire), .SDA_OUT(sda_out),
        .SDA_OE_N(sda_oe_n), .BUS_ID_STRAPS(MY_ID), .SLEEP_INPUT(sleep),
        .LINK_OUT_EN(link_en));
    bus_host u_host (.clk(clk), .scl(scl), .sda_low(sda_low),
        .sda_in(sda_wire));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        if (fail_count == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cycles++;
        if (cycles > 60000)
        begin
            fail_count++;
            tally_and_finish();
        end
        if (rst_n && scl === 1'b1)
            check(sda_oe_n, oe_prev);
        if (sda_oe_n === 1'b0)
            check(sda_out, 1'b0);
        oe_prev <= sda_oe_n;
    end
    task automatic write_run(input logic [7:0] idx, input logic [7:0] d0,
        input int n);
        u_host.start();
        u_host.xfer({MY_ID, 1'b0, 1'b1}, rx);
        check(rx[0], 1'b0);
        u_host.xfer({idx, 1'b1}, rx);
        check(rx[0], 1'b0);
        for (int k = 0; k < n; k++)
        begin
            u_host.xfer({d0 + 8'(k), 1'b1}, rx);
            check(rx[0], 1'b0);
        end
        u_host.stop();
    endtask
    task automatic read_run(input logic [7:0] idx, input logic [7:0] d0,
        input int n);
        u_host.start();
        u_host.xfer({MY_ID, 1'b0, 1'b1}, rx);
        u_host.xfer({idx, 1'b1}, rx);
        u_host.start();
        u_host.xfer({MY_ID, 1'b1, 1'b1}, rx);
        check(rx[0], 1'b0);
        for (int k = 0; k < n; k++)
        begin
            u_host.xfer({8'hFF, k == n - 1}, rx);
            check(rx[8:1], d0 + 8'(k));
        end
        u_host.stop();
    endtask
    task automatic expect_en(input logic exp);
        for (int i = 0; i < 20 && link_en !== exp; i++)
        begin
            @(posedge clk);
            #5;
        end
        check(link_en, exp);
    endtask
    task automatic test_long();
        write_run(8'h00, 8'h40, 28);
        read_run(8'h00, 8'h40, 28);
    endtask
    task automatic test_wrap();
        write_run(8'h1A, 8'h5A, 3);
        read_run(8'h1A, 8'h5A, 3);
    endtask
    task automatic test_foreign();
        u_host.start();
        u_host.xfer({MY_ID ^ 7'h01, 1'b0, 1'b1}, rx);
        check(rx[0], 1'b1);
        u_host.xfer({8'h1A, 1'b1}, rx);
        check(rx[0], 1'b1);
        u_host.stop();
        read_run(8'h1A, 8'h5A, 1);
    endtask
    task automatic test_glitch();
        u_host.glitch = 1'b1;
        write_run(8'h03, 8'hC3, 1);
        u_host.glitch = 1'b0;
        read_run(8'h03, 8'hC3, 1);
    endtask
    task automatic test_link_off();
        // reg 0x05 still holds 0x45 from the long run, reg 0x02 holds 0x42
        logic [7:0] idx [8] = '{8'h02, 8'h05, 8'h02, 8'h02, 8'h05, 8'h05,
            8'h05, 8'h05};
        logic [7:0] val [8] = '{8'h00, 8'h00, 8'h20, 8'h00, 8'h01, 8'h02,
            8'h03, 8'h00};
        logic en [8] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
        for (int i = 0; i < 8; i++)
        begin
            write_run(idx[i], val[i], 1);
            expect_en(en[i]);
        end
        @(posedge clk);
        #2 sleep = 1'b1;
        expect_en(1'b0);
        @(posedge clk);
        #2 sleep = 1'b0;
        expect_en(1'b1);
    endtask
    initial
    begin
        repeat (8) @(posedge clk);
        #2;
        check(link_en, 1'b0);
        check(sda_oe_n, 1'b1);
        rst_n = 1'b1;
        repeat (10) @(posedge clk);
        #2;
        expect_en(1'b1);
        test_long();
        test_wrap();
        test_foreign();
        test_glitch();
        test_link_off();
        tally_and_finish();
    end
endmodule
